// ---- design/bus_match_pkg.sv ----
// Shared constants and types for the right-port width matcher.
// Assumes a single clock domain and a 36-bit memory word split into 9-bit lanes.
package bus_match_pkg;

    localparam int WORD_W = 36;
    localparam int LANE_W = 9;
    localparam int HALF_W = 18;
    localparam int LANE_N = 4;
    localparam int FIFO_DEPTH = 8;

    localparam logic [1:0] IDX_RESET = 2'h0;
    localparam logic [1:0] IDX_LOW = 2'h0;
    localparam logic [1:0] IDX_HALF_HIGH = 2'h1;
    localparam logic [1:0] IDX_BYTE_HIGH = 2'h3;
    localparam logic [1:0] IDX_STEP = 2'h1;
    localparam logic [35:0] WORD_ZERO = 36'h0;
    localparam logic [8:0] LANE_ZERO = 9'h0;

    typedef enum logic [2:0] {
        MODE_X36 = 3'b001,
        MODE_X18 = 3'b010,
        MODE_X9 = 3'b100
    } mode_e;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_WRITE = 3'b010,
        PH_READ = 3'b100
    } phase_e;

    // Width match low selects long-word whatever the width select shows
    function automatic mode_e decode_mode(input logic match_sel, input logic size_sel);
        mode_e m;
        m = MODE_X36;
        if (match_sel) begin
            m = size_sel ? MODE_X9 : MODE_X18;
        end
        return m;
    endfunction : decode_mode

    // Nine-bit lane number sel of a stored word
    function automatic logic [8:0] pick_lane(input logic [35:0] word, input logic [1:0] sel);
        logic [8:0] lane;
        lane = word[8:0];
        case (sel)
            2'h0: lane = word[8:0];
            2'h1: lane = word[17:9];
            2'h2: lane = word[26:18];
            2'h3: lane = word[35:27];
            default: lane = word[8:0];
        endcase
        return lane;
    endfunction : pick_lane

endpackage : bus_match_pkg

// ---- design/word_fifo.sv ----
// Word FIFO held in flip-flops, with valid and ready on both sides.
// Assumes the filler holds data stable while in_valid waits on in_ready.
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = count_r != FULL_COUNT;
    assign out_valid = count_r != '0;
    assign out_data = mem_r[rd_ptr_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST_SLOT) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST_SLOT) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : word_fifo
`default_nettype wire

// ---- design/lane_counter.sv ----
// Lane sub-counter that steps the right-port lane multiplexer.
// Assumes restart is raised by the caller whenever a new word begins.
`timescale 1ns/10ps
`default_nettype none
module lane_counter
    import bus_match_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire mode_e mode,
    input wire logic msb_first,
    input wire logic restart,
    input wire logic step,
    output logic [1:0] idx,
    output logic last
);
    logic [1:0] idx_r;
    logic [1:0] idx_nxt;
    wire [1:0] top_idx = (mode == MODE_X9) ? IDX_BYTE_HIGH :
                         (mode == MODE_X18) ? IDX_HALF_HIGH : IDX_LOW;
    wire [1:0] start_idx = msb_first ? top_idx : IDX_LOW;
    wire [1:0] end_idx = msb_first ? IDX_LOW : top_idx;

    assign idx = restart ? start_idx : idx_r;
    assign last = idx == end_idx;

    // Up for least-first, down for most-first
    // Wraps to the start lane after the final one
    assign idx_nxt = !step ? idx :
                     last ? start_idx :
                     msb_first ? idx - IDX_STEP : idx + IDX_STEP;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_r <= IDX_RESET;
        end else begin
            idx_r <= idx_nxt;
        end
    end
endmodule : lane_counter
`default_nettype wire

// ---- design/right_port_bus_width_matcher.sv ----
// Right-port bus width matcher: moves 36-bit memory words over a 36, 18 or 9 bit port.
// Assumes the host drives port strobes synchronous to clk and holds the selects static,
// and that the memory core holds mem_rd_data stable while mem_rd_valid is high.
//
// Behaviour
// - Both selects low: long-word mode, full 36 bits in one transfer.
// - Long-word mode has no per-byte write selection; whole word written.
// - Lane order select is ignored in long-word mode.
// - Match high, width low: 18-bit mode on data lines 0 to 17.
// - 18-bit, order low: least significant half moves first.
// - 18-bit, order high: most significant half moves first.
// - 18-bit word takes at least two port cycles.
// - Sub-counter steps the lane multiplexer on every transfer in narrow modes.
// - Each partial transfer maps to its own section of the stored word.
// - Match high, width high: 9-bit mode on data lines 0 to 8.
// - 9-bit, order low: least significant lane moves first.
// - 9-bit, order high: most significant lane moves first.
// - 9-bit word takes at least four port cycles.
// - In 9-bit mode data lines 9 to 35 stay undriven.
// - Sub-counter counts up for least-first, down for most-first.
`timescale 1ns/10ps
`default_nettype none
module right_port_bus_width_matcher
    import bus_match_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic width_match_select,
    input wire logic width_select,
    input wire logic lane_order_select,
    input wire logic port_xfer,
    input wire logic port_we,
    output logic port_ready,
    input wire logic [35:0] port_dq_in,
    output logic [35:0] port_dq_out,
    output logic [35:0] port_dq_oe,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [35:0] mem_wr_data,
    input wire logic mem_rd_valid,
    output logic mem_rd_ready,
    input wire logic [35:0] mem_rd_data,
    output logic port_busy
);
    // Mode and lane order
    mode_e mode;
    wire is_x36;
    wire is_x18;
    wire is_x9;
    wire msb_first;

    // Sequencing
    phase_e phase_r;
    phase_e phase_nxt;
    wire new_word;
    wire take;
    wire wr_take;
    wire rd_take;
    wire [1:0] idx;
    wire lane_last;

    // Write assembly
    logic [35:0] asm_r;
    logic [35:0] asm_nxt;
    wire [35:0] asm_base;
    wire [35:0] merged;
    wire fifo_in_valid;
    wire fifo_in_ready;

    // Read serialisation
    logic [35:0] dq_out_r;
    logic [35:0] dq_out_nxt;
    logic [35:0] dq_oe_r;
    logic [35:0] dq_oe_nxt;
    wire [35:0] rd_lanes;
    wire [35:0] rd_drive;

    // Selects are static; the undefined code falls back to long-word
    assign mode = decode_mode(width_match_select, width_select);
    assign is_x36 = mode == MODE_X36;
    assign is_x18 = mode == MODE_X18;
    assign is_x9 = mode == MODE_X9;

    // Order input only matters in the narrow modes
    assign msb_first = !is_x36 && lane_order_select;

    // A word starts fresh when idle or when the host turns direction mid-word
    assign new_word = (phase_r == PH_IDLE) ||
                      (phase_r == PH_WRITE && !port_we) ||
                      (phase_r == PH_READ && port_we);

    lane_counter u_lane_counter (
        .clk(clk),
        .rst(rst),
        .mode(mode),
        .msb_first(msb_first),
        .restart(new_word),
        .step(take),
        .idx(idx),
        .last(lane_last)
    );

    // Only the final lane of a write needs FIFO room; reads wait on a stored word
    assign port_ready = port_we ? (!lane_last || fifo_in_ready) : mem_rd_valid;
    assign take = port_xfer && port_ready;
    assign wr_take = take && port_we;
    assign rd_take = take && !port_we;

    assign asm_base = new_word ? WORD_ZERO : asm_r;

    generate
        for (genvar k = 0; k < LANE_N; k++) begin : g_lane
            localparam logic [1:0] LANE_ID = 2'(k);
            wire lane_we;
            wire [8:0] lane_src;
            wire [1:0] rd_src;
            wire rd_use;

            // Long-word writes every lane together, no byte mask
            assign lane_we = is_x36 ||
                             (is_x18 && idx[0] == LANE_ID[1]) ||
                             (is_x9 && idx == LANE_ID);
            assign lane_src = is_x36 ? port_dq_in[k*LANE_W +: LANE_W] :
                              (is_x18 && LANE_ID[0]) ? port_dq_in[17:9] :
                              port_dq_in[8:0];
            assign merged[k*LANE_W +: LANE_W] = lane_we ? lane_src :
                                                asm_base[k*LANE_W +: LANE_W];

            // Port lane k reads stored lane k in long-word mode, else the stored lane picked by the sub-counter
            assign rd_src = is_x36 ? LANE_ID :
                            is_x18 ? {idx[0], LANE_ID[0]} : idx;
            // Upper lines stay undriven in the narrow modes
            assign rd_use = is_x36 ||
                            (is_x18 && !LANE_ID[1]) ||
                            (is_x9 && LANE_ID == IDX_LOW);
            assign rd_lanes[k*LANE_W +: LANE_W] = rd_use ?
                                                  pick_lane(mem_rd_data, rd_src) : LANE_ZERO;
            assign rd_drive[k*LANE_W +: LANE_W] = {LANE_W{rd_use}};
        end
    endgenerate

    // Whole word is pushed on the final lane only
    assign fifo_in_valid = wr_take && lane_last;
    assign asm_nxt = wr_take ? merged : asm_r;

    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(merged),
        .out_valid(mem_wr_valid),
        .out_ready(mem_wr_ready),
        .out_data(mem_wr_data)
    );

    // Stored word is released after its final lane has been read
    assign mem_rd_ready = rd_take && lane_last;

    // Read data and enables are registered, shown the cycle after the take
    assign dq_out_nxt = rd_take ? rd_lanes : dq_out_r;
    assign dq_oe_nxt = rd_take ? rd_drive : WORD_ZERO;

    always_comb begin
        phase_nxt = phase_r;
        if (take) begin
            if (lane_last) begin
                phase_nxt = PH_IDLE;
            end else if (port_we) begin
                phase_nxt = PH_WRITE;
            end else begin
                phase_nxt = PH_READ;
            end
        end
        case (phase_nxt)
            PH_IDLE: phase_nxt = PH_IDLE;
            PH_WRITE: phase_nxt = PH_WRITE;
            PH_READ: phase_nxt = PH_READ;
            default: phase_nxt = PH_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= PH_IDLE;
            asm_r <= WORD_ZERO;
            dq_out_r <= WORD_ZERO;
            dq_oe_r <= WORD_ZERO;
        end else begin
            phase_r <= phase_nxt;
            asm_r <= asm_nxt;
            dq_out_r <= dq_out_nxt;
            dq_oe_r <= dq_oe_nxt;
        end
    end

    assign port_dq_out = dq_out_r;
    assign port_dq_oe = dq_oe_r;
    assign port_busy = phase_r != PH_IDLE;

endmodule : right_port_bus_width_matcher
`default_nettype wire

// ---- verif/bus_match_chk.sv ----
// Port-level assertions for the right-port width matcher.
// Assumes the selects change only while reset is held.
`timescale 1ns/10ps
`default_nettype none
module bus_match_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic width_match_select,
    input wire logic width_select,
    input wire logic port_xfer,
    input wire logic port_we,
    input wire logic port_ready,
    input wire logic [35:0] port_dq_oe,
    input wire logic mem_wr_valid,
    input wire logic mem_wr_ready,
    input wire logic [35:0] mem_wr_data,
    input wire logic mem_rd_ready,
    input wire logic port_busy
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence rd_take;
        port_xfer && port_ready && !port_we;
    endsequence
    sequence wr_take;
        port_xfer && port_ready && port_we;
    endsequence
    long_oe_a: assert property (rd_take |=> width_match_select || &port_dq_oe)
        else $error("long read enables wrong");
    half_oe_a: assert property (rd_take |=> !width_match_select || width_select
        || port_dq_oe == 36'h00003FFFF) else $error("half read enables wrong");
    byte_oe_a: assert property (rd_take |=> !width_match_select || !width_select
        || port_dq_oe == 36'h0000001FF) else $error("byte read enables wrong");
    byte_hiz_a: assert property (width_match_select && width_select |->
        port_dq_oe[35:9] == 27'h0) else $error("upper lines driven in byte mode");
    long_push_a: assert property (wr_take |=> width_match_select || mem_wr_valid)
        else $error("long write not pushed");
    long_read_a: assert property (rd_take |-> width_match_select || mem_rd_ready)
        else $error("long read not single");
    narrow_final_a: assert property (mem_rd_ready && width_match_select |->
        port_busy) else $error("narrow word ended on first lane");
    push_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=>
        mem_wr_valid && $stable(mem_wr_data)) else $error("pushed word not held");
endmodule : bus_match_chk
bind right_port_bus_width_matcher bus_match_chk chk_u (
    .clk(clk), .rst(rst), .width_match_select(width_match_select),
    .width_select(width_select), .port_xfer(port_xfer), .port_we(port_we),
    .port_ready(port_ready), .port_dq_oe(port_dq_oe), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_data(mem_wr_data),
    .mem_rd_ready(mem_rd_ready), .port_busy(port_busy)
);
`default_nettype wire

// ---- verif/mem_core_model.sv ----
// Memory core stand-in: sinks pushed words, offers one word for reading.
// Assumes load is raised for one cycle while no word is on offer.
`timescale 1ns/10ps
`default_nettype none
module mem_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic load,
    input wire logic [35:0] load_word,
    input wire logic mem_wr_valid,
    output logic mem_wr_ready,
    input wire logic [35:0] mem_wr_data,
    output logic mem_rd_valid,
    input wire logic mem_rd_ready,
    output logic [35:0] mem_rd_data,
    output logic [7:0] wr_count,
    output logic [35:0] last_wr
);
    logic [35:0] word_r;
    assign mem_wr_ready = !stall;
    // Offered word stands until taken; afterwards its inverse shows
    assign mem_rd_data = mem_rd_valid ? word_r : ~word_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_rd_valid <= 1'b0;
            word_r <= 36'h0;
            wr_count <= 8'h0;
            last_wr <= 36'h0;
        end else begin
            if (load) begin
                mem_rd_valid <= 1'b1;
                word_r <= load_word;
            end else if (mem_rd_ready) begin
                mem_rd_valid <= 1'b0;
            end
            if (mem_wr_valid && mem_wr_ready) begin
                wr_count <= wr_count + 8'h1;
                last_wr <= mem_wr_data;
            end
        end
    end
endmodule : mem_core_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Bench for the width matcher: word moves in all widths and orders, FIFO fill.
// Assumes mem_core_model stands on the memory side.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic m_sel = 1'b0;
    logic w_sel = 1'b0;
    logic o_sel = 1'b0;
    logic xfer = 1'b0;
    logic we = 1'b0;
    logic stall = 1'b0;
    logic load = 1'b0;
    logic [35:0] dq_in = 36'h0;
    logic [35:0] load_word = 36'h0;
    logic ready, wv, wr_rdy, rv, rr, busy;
    logic [35:0] dq_out, dq_oe, wd, rd, last_wr;
    logic [7:0] wr_count;
    int num_errors = 0;
    int total_checks = 0;
    right_port_bus_width_matcher dut_u (.clk(clk), .rst(rst), .width_match_select(m_sel),
        .width_select(w_sel), .lane_order_select(o_sel), .port_xfer(xfer), .port_we(we),
        .port_ready(ready), .port_dq_in(dq_in), .port_dq_out(dq_out), .port_dq_oe(dq_oe),
        .mem_wr_valid(wv), .mem_wr_ready(wr_rdy), .mem_wr_data(wd), .mem_rd_valid(rv),
        .mem_rd_ready(rr), .mem_rd_data(rd), .port_busy(busy));
    mem_core_model core_u (.clk(clk), .rst(rst), .stall(stall), .load(load),
        .load_word(load_word), .mem_wr_valid(wv), .mem_wr_ready(wr_rdy), .mem_wr_data(wd),
        .mem_rd_valid(rv), .mem_rd_ready(rr), .mem_rd_data(rd), .wr_count(wr_count),
        .last_wr(last_wr));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic set_mode(input int m, input logic be);
        rst <= 1'b1;
        m_sel <= (m == 1 || m == 2);
        w_sel <= (m >= 2);
        o_sel <= be;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : set_mode
    // One lane; writes keep xfer high for back-to-back lanes
    task automatic lane(input logic w, input logic [35:0] d, input logic [35:0] mask);
        logic r;
        r = 1'b0;
        xfer <= 1'b1;
        we <= w;
        dq_in <= d;
        for (int n = 0; n < 50 && !r; n++) begin
            @(negedge clk);
            r = ready;
            @(posedge clk);
        end
        if (r !== 1'b1) begin
            num_errors++;
            results();
        end
        if (!w) begin
            xfer <= 1'b0;
            @(negedge clk);
            chk(dq_out & mask, d);
            chk(dq_oe, mask);
            @(posedge clk);
        end
    endtask : lane
    task automatic word_io(input int m, input logic be, input logic [35:0] word);
        logic [35:0] mask;
        int w, n, idx;
        w = 36 >> m;
        n = 1 << m;
        mask = {36{1'b1}} >> (36 - w);
        for (int k = 0; k < n; k++) begin
            idx = be ? n - 1 - k : k;
            lane(1'b1, (word >> (idx * w)) & mask, mask);
        end
        xfer <= 1'b0;
        for (int k = 0; k < 20 && last_wr !== word; k++) begin
            @(posedge clk);
        end
        chk(last_wr, word);
        load <= 1'b1;
        load_word <= word;
        @(posedge clk);
        load <= 1'b0;
        for (int k = 0; k < n; k++) begin
            idx = be ? n - 1 - k : k;
            lane(1'b0, (word >> (idx * w)) & mask, mask);
            chk({35'h0, busy}, {35'h0, k < n - 1});
        end
    endtask : word_io
    task automatic sc_widths;
        for (int m = 0; m < 3; m++) begin
            for (int be = 0; be < 2; be++) begin
                set_mode(m, be[0]);
                word_io(m, be[0], 36'h9A5C3E1B7);
                word_io(m, be[0], 36'h1236DF0E5);
                $display("widths mode %0d order %0d done", m, be);
            end
        end
        // Match low with width high is taken as long-word
        set_mode(3, 1'b1);
        word_io(0, 1'b1, 36'h5A5A0F0F3);
        $display("widths odd select code done");
    endtask : sc_widths
    task automatic sc_fifo;
        set_mode(0, 1'b0);
        stall <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            lane(1'b1, 36'h100000000 + 36'(k), {36{1'b1}});
        end
        dq_in <= 36'hFEDCBA987;
        @(negedge clk);
        chk({35'h0, ready}, 36'h0);
        @(posedge clk);
        xfer <= 1'b0;
        stall <= 1'b0;
        for (int k = 0; k < 40 && wr_count !== 8'h8; k++) begin
            @(posedge clk);
        end
        chk({28'h0, wr_count}, 36'h8);
        chk(last_wr, 36'h100000007);
        $display("fifo fill done");
    endtask : sc_fifo
    // A read after one written byte drops the partial word and starts at lane 0
    task automatic sc_turn;
        set_mode(2, 1'b0);
        load <= 1'b1;
        load_word <= 36'h0F1E2D3C4;
        @(posedge clk);
        load <= 1'b0;
        lane(1'b1, 36'h0AB, 36'h1FF);
        for (int k = 0; k < 4; k++) begin
            lane(1'b0, (36'h0F1E2D3C4 >> (k * 9)) & 36'h1FF, 36'h1FF);
        end
        chk({28'h0, wr_count}, 36'h0);
        $display("turn done");
    endtask : sc_turn
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        sc_widths();
        sc_fifo();
        sc_turn();
        results();
    end
endmodule : tb_top
`default_nettype wire
